// ===== psw_pkg.sv
// Package for the program status word block: offsets, fields, operations
package psw_pkg;
    localparam logic [7:0] PSW_SFR_ADDR = 8'hD0;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam int PSW_CY_BIT = 7;
    localparam int PSW_AC_BIT = 6;
    localparam int PSW_F0_BIT = 5;
    localparam int PSW_RS_HI = 4;
    localparam int PSW_RS_LO = 3;
    localparam int PSW_OV_BIT = 2;
    localparam int PSW_F1_BIT = 1;
    localparam int PSW_P_BIT = 0;
    localparam logic [7:0] PSW_BANK_STEP = 8'h08;
    localparam logic [8:0] PSW_BYTE_MAX = 9'h0FF;

    typedef enum logic [2:0] {
        PSW_OP_NONE = 3'b000,
        PSW_OP_ADD = 3'b001,
        PSW_OP_ADD_CARRY = 3'b010,
        PSW_OP_SUB_BORROW = 3'b011,
        PSW_OP_MUL = 3'b100,
        PSW_OP_DIV = 3'b101,
        PSW_OP_OTHER = 3'b110
    } psw_op_t;
endpackage : psw_pkg

// ===== psw_alu_flags.sv
// Flag computation for one arithmetic result
`timescale 1ns/1ps
module psw_alu_flags
    import psw_pkg::*;
(
    // Operation and operands
    input wire psw_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cin,
    // Flags
    output logic o_cy,
    output logic o_ac,
    output logic o_ov,
    output logic o_cy_upd,
    output logic o_ov_upd
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [15:0] prod;
    logic cin_eff;

    always_comb begin
        cin_eff = (i_op == PSW_OP_ADD) ? 1'b0 : i_cin;
        sum = 9'h000;
        nib = 5'h00;
        prod = 16'({8'h00, i_a} * {8'h00, i_b});
        o_cy = 1'b0;
        o_ac = 1'b0;
        o_ov = 1'b0;
        o_cy_upd = 1'b0;
        o_ov_upd = 1'b0;
        unique case (i_op)
            PSW_OP_ADD, PSW_OP_ADD_CARRY: begin
                sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin_eff};
                nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin_eff};
                o_cy = sum[8];
                o_ac = nib[4];
                o_ov = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
                o_cy_upd = 1'b1;
                o_ov_upd = 1'b1;
            end
            PSW_OP_SUB_BORROW: begin
                sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
                nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, i_cin};
                o_cy = sum[8];
                o_ac = nib[4];
                o_ov = (i_a[7] != i_b[7]) && (sum[7] != i_a[7]);
                o_cy_upd = 1'b1;
                o_ov_upd = 1'b1;
            end
            PSW_OP_MUL: begin
                o_ov = ({1'b0, prod[15:8]} != 9'h000) && (prod > 16'(PSW_BYTE_MAX));
                o_cy_upd = 1'b1;
                o_ov_upd = 1'b1;
            end
            PSW_OP_DIV: begin
                o_ov = (i_b == 8'h00);
                o_cy_upd = 1'b1;
                o_ov_upd = 1'b1;
            end
            PSW_OP_OTHER: begin
                o_cy_upd = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule : psw_alu_flags

// ===== psw_status_word.sv
// Program status word register with flag update, bit access and bank select
// Functional notes
// - Carry set on add carry or subtract borrow, cleared by other arithmetic.
// - Half carry set on carry into or borrow from upper nibble.
// - Two user flags keep written value; hardware never alters them.
// - Bank select picks one eight-byte working register group.
// - Overflow set on signed overflow of add, add-with-carry, subtract.
// - Overflow set when multiply product exceeds 255.
// - Overflow set on divide by zero.
// - Otherwise those five instructions clear overflow.
// - Parity bit is read-only, one when accumulator has odd ones.
// - Word sits at special address 0xD0, bit-accessible, resets to zero.
// - Program and data spaces share addresses; instruction type selects.
// - Working registers live at internal RAM 0x00-0x1F, one bank active.
`timescale 1ns/1ps
module psw_status_word
    import psw_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Special function register access
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_bit_wr,
    input wire logic [2:0] i_bit_sel,
    input wire logic i_bit_val,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // Datapath
    input wire psw_op_t i_op,
    input wire logic [7:0] i_op_a,
    input wire logic [7:0] i_op_b,
    input wire logic [7:0] i_acc,
    input wire logic i_code_space,
    input wire logic [2:0] i_reg_index,
    // Status outputs
    output logic [7:0] o_psw,
    output logic [7:0] o_reg_addr,
    output logic o_code_sel
);
    logic [7:0] psw;
    logic [7:0] next_psw;
    logic [7:0] next_rdata;
    logic next_hit;
    logic [7:0] reg_addr;
    logic [7:0] next_reg_addr;
    logic code_sel;
    logic next_code_sel;
    logic hw_cy, hw_ac, hw_ov, cy_upd, ov_upd;

    psw_alu_flags u_flags (
        .i_op(i_op),
        .i_a(i_op_a),
        .i_b(i_op_b),
        .i_cin(psw[PSW_CY_BIT]),
        .o_cy(hw_cy),
        .o_ac(hw_ac),
        .o_ov(hw_ov),
        .o_cy_upd(cy_upd),
        .o_ov_upd(ov_upd)
    );

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == PSW_SFR_ADDR);
    endfunction : addr_hit

    always_comb begin
        next_psw = psw;
        if (addr_hit(i_sfr_addr) && i_sfr_wr) begin
            next_psw = i_sfr_wdata;
        end else if (addr_hit(i_sfr_addr) && i_bit_wr) begin
            next_psw[i_bit_sel] = i_bit_val;
        end
        if (cy_upd) begin
            next_psw[PSW_CY_BIT] = hw_cy;
            next_psw[PSW_AC_BIT] = hw_ac;
        end
        if (ov_upd) begin
            next_psw[PSW_OV_BIT] = hw_ov;
        end
        next_psw[PSW_P_BIT] = ^i_acc;
        next_hit = addr_hit(i_sfr_addr);
        next_rdata = next_hit ? {psw[7:1], ^i_acc} : 8'h00;
        next_reg_addr = 8'({3'b000, next_psw[PSW_RS_HI:PSW_RS_LO], i_reg_index});
        next_code_sel = i_code_space;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            psw <= PSW_RESET;
            o_sfr_rdata <= 8'h00;
            o_sfr_hit <= 1'b0;
            reg_addr <= 8'h00;
            code_sel <= 1'b0;
        end else begin
            psw <= next_psw;
            o_sfr_rdata <= next_rdata;
            o_sfr_hit <= next_hit;
            reg_addr <= next_reg_addr;
            code_sel <= next_code_sel;
        end
    end

    assign o_psw = psw;
    assign o_reg_addr = reg_addr;
    assign o_code_sel = code_sel;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence user_write_s;
        addr_hit(i_sfr_addr) && i_sfr_wr;
    endsequence

    user_flags_keep_a: assert property (!(addr_hit(i_sfr_addr) && (i_sfr_wr || i_bit_wr))
        |=> $stable({psw[PSW_F0_BIT], psw[PSW_F1_BIT]}))
        else $error("user flag changed without write");
    user_flags_write_a: assert property (user_write_s
        |=> psw[PSW_F0_BIT] == $past(i_sfr_wdata[PSW_F0_BIT]))
        else $error("user flag write lost");
    carry_update_a: assert property (cy_upd |=> psw[PSW_CY_BIT] == $past(hw_cy))
        else $error("carry not updated");
    half_carry_a: assert property (cy_upd |=> psw[PSW_AC_BIT] == $past(hw_ac))
        else $error("half carry not updated");
    add_ovf_a: assert property ((i_op == PSW_OP_ADD) && (i_op_a == 8'h7F) && (i_op_b == 8'h01)
        |=> psw[PSW_OV_BIT])
        else $error("add overflow missed");
    mul_ovf_a: assert property ((i_op == PSW_OP_MUL) |=>
        psw[PSW_OV_BIT] == ($past(i_op_a) * $past(i_op_b) > 255))
        else $error("multiply overflow wrong");
    div_zero_a: assert property ((i_op == PSW_OP_DIV) |=>
        psw[PSW_OV_BIT] == ($past(i_op_b) == 8'h00))
        else $error("divide overflow wrong");
    parity_bit_a: assert property (##1 psw[PSW_P_BIT] == ^$past(i_acc))
        else $error("parity wrong");
    bank_addr_a: assert property (##1 o_reg_addr ==
        {3'b000, psw[PSW_RS_HI:PSW_RS_LO], $past(i_reg_index)})
        else $error("bank address wrong");
    hw_wins_a: assert property (user_write_s ##0 ov_upd |=> psw[PSW_OV_BIT] == $past(hw_ov))
        else $error("software write beat hardware");
endmodule : psw_status_word

// ===== psw_exec_model.sv
// Behavioural model of the instruction datapath feeding the status word
`timescale 1ns/1ps
module psw_exec_model
    import psw_pkg::*;
(
    // Operation and operands
    output psw_op_t o_op,
    output logic [7:0] o_a,
    output logic [7:0] o_b,
    output logic [7:0] o_acc
);
    task automatic exec(input psw_op_t op, input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] acc);
        o_op = op;
        o_a = a;
        o_b = b;
        o_acc = acc;
    endtask : exec
    initial exec(PSW_OP_NONE, 8'h00, 8'h00, 8'h00);
endmodule : psw_exec_model

// ===== program_status_flags_test.sv
// Self-checking bench for the program status word
`timescale 1ns/1ps
module program_status_flags_test
    import psw_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic bw = 1'b0;
    logic bv = 1'b0;
    logic cs = 1'b0;
    logic [7:0] ad = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [2:0] bs = 3'h0;
    logic [2:0] ri = 3'h0;
    psw_op_t op;
    logic [7:0] a, b, acc, rdata, psw, raddr, ep, cacc;
    logic hit, csel;
    logic [16:0] e;
    logic [16:0] q[$];
    int error_cnt = 0;
    int comparisons = 0;
    psw_op_t ops[6] = '{PSW_OP_ADD, PSW_OP_SUB_BORROW, PSW_OP_MUL, PSW_OP_MUL, PSW_OP_DIV,
        PSW_OP_DIV};
    logic [7:0] xs[6] = '{8'h7F, 8'h80, 8'h0F, 8'h10, 8'h33, 8'h33};
    logic [7:0] ys[6] = '{8'h01, 8'h01, 8'h11, 8'h10, 8'h00, 8'h07};
    always #2 clk = ~clk;
    psw_exec_model i_psw_exec_model(.o_op(op), .o_a(a), .o_b(b), .o_acc(acc));
    psw_status_word i_psw_status_word(.i_core_clk(clk), .i_reset_n(rst_n), .i_sfr_addr(ad),
        .i_sfr_wr(wr), .i_sfr_wdata(wd), .i_bit_wr(bw), .i_bit_sel(bs), .i_bit_val(bv),
        .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_op(op), .i_op_a(a), .i_op_b(b), .i_acc(acc),
        .i_code_space(cs), .i_reg_index(ri), .o_psw(psw), .o_reg_addr(raddr), .o_code_sel(csel));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    function automatic logic [7:0] upd(logic [7:0] p, psw_op_t o, logic [7:0] x, logic [7:0] y,
        logic cy_in);
        logic [8:0] s;
        logic c;
        c = (o == PSW_OP_ADD) ? 1'b0 : cy_in;
        case (o)
            PSW_OP_ADD, PSW_OP_ADD_CARRY: begin
                s = x + y + c;
                p[6] = (x[3:0] + y[3:0] + c) > 5'h0F;
                p[2] = (x[7] == y[7]) && (s[7] != x[7]);
                p[7] = s[8];
            end
            PSW_OP_SUB_BORROW: begin
                s = {1'b0, x} - y - c;
                p[6] = {1'b0, x[3:0]} < y[3:0] + c;
                p[2] = (x[7] != y[7]) && (s[7] != x[7]);
                p[7] = s[8];
            end
            PSW_OP_MUL: p[7:2] = {2'b00, p[5:3], (x * y) > 16'h00FF};
            PSW_OP_DIV: p[7:2] = {2'b00, p[5:3], y == 8'h00};
            PSW_OP_OTHER: p[7:6] = 2'b00;
            default: ;
        endcase
        return p;
    endfunction : upd
    // One cycle of stimulus; expected read result noted for the watcher
    task automatic step(input logic [7:0] sa, input logic sw, input logic [7:0] sd,
        input logic sb, input logic [2:0] sel, input logic sv, input psw_op_t so,
        input logic [7:0] x, input logic [7:0] y, input logic [7:0] sac);
        logic old_cy;
        @(negedge clk);
        old_cy = ep[7];
        ad = sa;
        wr = sw;
        wd = sd;
        bw = sb;
        bs = sel;
        bv = sv;
        cs = 1'($urandom);
        ri = 3'($urandom);
        i_psw_exec_model.exec(so, x, y, sac);
        if (sa == PSW_SFR_ADDR && sw) ep[7:1] = sd[7:1];
        else if (sa == PSW_SFR_ADDR && sb && sel != 3'h0) ep[sel] = sv;
        ep = upd(ep, so, x, y, old_cy);
        ep[0] = ^sac;
        cacc = sac;
        if (sa == PSW_SFR_ADDR) q.push_back({!sw && !sb && so == PSW_OP_NONE, ep, 3'h0, ep[4:3], ri});
    endtask : step
    task automatic rd;
        step(PSW_SFR_ADDR, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0, PSW_OP_NONE, 8'h00, 8'h00, cacc);
    endtask : rd
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        #1;
        if (hit === 1'b1) begin
            if (q.size() == 0) cmp({7'h00, hit}, 8'h00);
            else begin
                e = q.pop_front();
                if (e[16]) cmp(rdata, e[15:8]);
                if (e[16]) cmp(raddr, e[7:0]);
            end
        end
        if (rst_n === 1'b1) begin
            cmp(psw, ep);
            cmp({7'h00, csel}, {7'h00, cs});
        end
    end
    initial begin
        void'($urandom(83458));
        ep = 8'h00;
        cacc = 8'h00;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        rd();
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            step(PSW_SFR_ADDR, 1'b1, {3'($urandom), 2'(k), 3'($urandom)}, 1'b0, 3'h0, 1'b0,
                PSW_OP_NONE, 8'h00, 8'h00, cacc);
            rd();
        end
        for (int k = 0; k < 16; k++) begin
            step(PSW_SFR_ADDR, 1'b0, 8'h00, 1'b1, 3'(k), k[3], PSW_OP_NONE, 8'h00, 8'h00,
                8'(k * 37));
            rd();
        end
        step(8'hD1, 1'b1, 8'hFF, 1'b1, 3'h5, 1'b1, PSW_OP_NONE, 8'h00, 8'h00, cacc);
        rd();
        $display("test bank and bit access done");
        for (int k = 0; k < 6; k++) begin
            step(8'h00, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0, ops[k], xs[k], ys[k], 8'h5A);
            rd();
        end
        step(PSW_SFR_ADDR, 1'b1, 8'hFF, 1'b1, 3'h5, 1'b0, PSW_OP_ADD, 8'h01, 8'h01, cacc);
        rd();
        for (int k = 0; k < 300; k++) begin
            step(($urandom % 3 == 0) ? PSW_SFR_ADDR : 8'($urandom), 1'($urandom), 8'($urandom),
                1'($urandom), 3'($urandom), 1'($urandom), psw_op_t'($urandom % 7),
                8'($urandom), 8'($urandom % 5 == 0 ? 0 : $urandom), 8'($urandom));
            rd();
        end
        $display("test arithmetic flags done");
        step(8'h00, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0, PSW_OP_NONE, 8'h00, 8'h00, cacc);
        for (int k = 0; k < 10 && q.size() != 0; k++) @(negedge clk);
        if (q.size() != 0) error_cnt++;
        tally_and_finish();
    end
endmodule : program_status_flags_test
